// ---- hw/cwda_defines.vh ----
// Contract
// - The short word compare subtracts a 16-bit immediate from the chosen register and uses the difference only for the flags.
// - The short word compare never writes the register; only the condition flags change.
// - The short word compare is one byte shorter and one state faster than the general word-immediate compare.
// - After the short word compare, N is set when the difference is negative and Z when it is zero, else each is cleared.
// - After the short word compare, V is set when the 16-bit signed subtraction overflows, else cleared.
// - After the short word compare, C is set when the subtraction borrows, else cleared.
// - The decimal add sums the two register low bytes as two-digit BCD plus C and writes the sum back to the destination.
// - The decimal add keeps N and V as they were.
// - The decimal add sets Z only when Z was already set and the sum is zero, else clears it.
// - The decimal add sets C on a decimal carry out of two digits, else clears it.
// - The decimal add with word size gives an undefined result; only byte size must be correct.
`ifndef CWDA_DEFINES_VH
`define CWDA_DEFINES_VH
`define CWDA_ADDR_CTRL       32'h0000_0000
`define CWDA_ADDR_STAT       32'h0000_0004
`define CWDA_ADDR_FLAGS      32'h0000_0008
`define CWDA_ADDR_REGBASE    32'h0000_0020
`define CWDA_CMPI_PATTERN    5'h09
`define CWDA_BCD_ADD_WITH_CARRY_OP1_TOP    4'hA
`define CWDA_BCD_ADD_WITH_CARRY_OP1_HI     5'h14
`define CWDA_BCD_ADD_WITH_CARRY_OP2        8'hA0
`define CWDA_BCD_ADD_WITH_CARRY_OP3_HI     5'h14
`define CWDA_FLAG_C          0
`define CWDA_FLAG_V          1
`define CWDA_FLAG_Z          2
`define CWDA_FLAG_N          3
`define CWDA_FLAGS_RESET     4'h0
`define CWDA_CMPI_STATES     8'h03
`define CWDA_CMPG_STATES     8'h04
`define CWDA_CMPI_BYTES      8'h03
`define CWDA_CMPG_BYTES      8'h04
`define CWDA_BCD_ADD_WITH_CARRY_STATES     8'h03
`define CWDA_BCD_ADD_WITH_CARRY_BYTES      8'h03
`endif

// ---- hw/cwda_top.v ----
`timescale 1ns/1ps
`include "cwda_defines.vh"
module cwda_top (
    input  wire        hclk,       // CPU clock, 100 MHz
    input  wire        hresetn,    // Asynchronous reset, active low
    input  wire        hsel,       // AHB select
    input  wire [31:0] haddr,      // AHB address
    input  wire [1:0]  htrans,     // AHB transfer type
    input  wire        hwrite,     // AHB write
    input  wire [2:0]  hsize,      // AHB size
    input  wire        hready,     // AHB ready in
    input  wire [31:0] hwdata,     // AHB write data
    output reg  [31:0] hrdata,     // AHB read data
    output wire        hreadyout,  // AHB ready out
    output wire        hresp,      // AHB response
    input  wire [7:0]  ibyte,      // Instruction stream byte
    input  wire        ibyte_vld,  // Instruction byte valid
    output wire        ibyte_rdy,  // Byte accepted
    output reg         busy_ff     // Instruction in progress
);
    // Ten states, one-hot; S_TAKES collects the states that accept a byte
    localparam [9:0] S_IDLE   = 10'h001;
    localparam [9:0] S_CI_H   = 10'h002;
    localparam [9:0] S_CI_L   = 10'h004;
    localparam [9:0] S_CI_EX  = 10'h008;
    localparam [9:0] S_DA_B2  = 10'h010;
    localparam [9:0] S_DA_B3  = 10'h020;
    localparam [9:0] S_DA_EX  = 10'h040;
    localparam [9:0] S_WAIT   = 10'h080;
    localparam [9:0] S_DA_BAD = 10'h100;
    localparam [9:0] S_SKIP   = 10'h200;
    localparam [9:0] S_TAKES  = S_IDLE | S_CI_H | S_CI_L | S_DA_B2 | S_DA_B3;

    // Architectural state
    reg  [15:0] gr_ff [0:7];        // General registers
    reg  [3:0]  flags_ff;           // condition_flags_register: N Z V C
    // Instruction decode state
    reg  [9:0]  state_ff;           // Decoder and executor state
    reg  [2:0]  rd_ff;              // Destination register number
    reg  [2:0]  rs_ff;              // Source register number
    reg         wsize_ff;           // Decimal add was coded with word size
    reg  [15:0] imm_ff;             // Immediate word, high byte first
    reg  [7:0]  states_ff;          // States used by last instruction
    reg  [7:0]  bytes_ff;           // Object bytes of last instruction
    // Bus side state
    reg         enable_ff;          // Software enable for the decoder
    reg  [31:0] aaddr_ff;           // Address of the pending data phase
    reg         awr_ff;             // Pending data phase is a write
    reg         aph_ff;             // A data phase is pending
    // Next values of the decode registers
    reg  [9:0]  nxt_state;
    reg  [3:0]  nxt_flags;
    reg  [2:0]  nxt_rd;
    reg  [2:0]  nxt_rs;
    reg         nxt_wsize;
    reg  [15:0] nxt_imm;
    reg  [7:0]  nxt_states;
    reg  [7:0]  nxt_bytes;
    reg         nxt_busy;
    reg         nxt_gr_we;          // Decimal sum goes to the register file
    reg  [31:0] rd_word;            // Read data for the address phase on the bus
    integer     i;

    // One BCD digit add; returns {carry, digit}
    function [4:0] bcd_digit;
        input [3:0] a;
        input [3:0] b;
        input       ci;
        reg   [4:0] s;
        begin
            s = {1'b0, a} + {1'b0, b} + {4'h0, ci};
            if (s > 5'd9) begin
                s = s + 5'd6;
                bcd_digit = {1'b1, s[3:0]};
            end else begin
                bcd_digit = s;
            end
        end
    endfunction

    // Two-digit decimal add; returns {carry, tens, units}
    function [8:0] bcd_byte;
        input [7:0] a;
        input [7:0] b;
        input       ci;
        reg   [4:0] lo;
        reg   [4:0] hi;
        begin
            // The units carry ripples into the tens digit
            lo       = bcd_digit(a[3:0], b[3:0], ci);
            hi       = bcd_digit(a[7:4], b[7:4], lo[4]);
            bcd_byte = {hi, lo[3:0]};
        end
    endfunction

    // Flags of a - b as {N, Z, V, C}; a borrow is the unsigned carry out
    function [3:0] cmp_word_flags;
        input [15:0] a;
        input [15:0] b;
        reg   [16:0] d;
        begin
            d = {1'b0, a} - {1'b0, b};
            cmp_word_flags[`CWDA_FLAG_N] = d[15];
            cmp_word_flags[`CWDA_FLAG_Z] = (d[15:0] == 16'h0000);
            cmp_word_flags[`CWDA_FLAG_V] = (a[15] != b[15]) && (d[15] != a[15]);
            cmp_word_flags[`CWDA_FLAG_C] = d[16];
        end
    endfunction

    // First byte of the short word compare: 01001 and a register number
    function is_cmpi_first;
        input [7:0] b;
        begin
            is_cmpi_first = (b[7:3] == `CWDA_CMPI_PATTERN);
        end
    endfunction

    // First byte of the decimal add: register direct, size bit, source number
    function is_bcd_add_with_carry_first;
        input [7:0] b;
        begin
            is_bcd_add_with_carry_first = (b[7:4] == `CWDA_BCD_ADD_WITH_CARRY_OP1_TOP);
        end
    endfunction

    // Second byte of the decimal add is a fixed code
    function is_bcd_add_with_carry_second;
        input [7:0] b;
        begin
            is_bcd_add_with_carry_second = (b == `CWDA_BCD_ADD_WITH_CARRY_OP2);
        end
    endfunction

    // Third byte of the decimal add carries the destination number
    function is_bcd_add_with_carry_last;
        input [7:0] b;
        begin
            is_bcd_add_with_carry_last = (b[7:3] == `CWDA_BCD_ADD_WITH_CARRY_OP3_HI);
        end
    endfunction

    // Word window of the eight general registers
    function in_reg_window;
        input [31:0] a;
        begin
            in_reg_window = ((a & 32'hffff_ffe0) == `CWDA_ADDR_REGBASE);
        end
    endfunction

    // Operands and results of the current instruction
    wire [15:0] dst_word  = gr_ff[rd_ff];
    wire [15:0] src_word  = gr_ff[rs_ff];
    wire [3:0]  cmp_flags = cmp_word_flags(dst_word, imm_ff);
    wire [8:0]  bcd_add_with_carry_out  = bcd_byte(dst_word[7:0], src_word[7:0],
                                     flags_ff[`CWDA_FLAG_C]);
    wire [7:0]  dsum      = bcd_add_with_carry_out[7:0];
    wire        dcarry    = bcd_add_with_carry_out[8];

    // Bytes are refused while an instruction executes, retires or is dropped
    assign ibyte_rdy = enable_ff && ((state_ff & S_TAKES) != 10'h000);
    wire take = ibyte_vld && ibyte_rdy;

    // AHB: only whole-word transfers are honoured; the slave never waits
    wire ahb_go  = hsel && hready && htrans[1] && (hsize == 3'b010);
    wire wr_ctrl = aph_ff && awr_ff && (aaddr_ff == `CWDA_ADDR_CTRL);
    wire wr_gr   = aph_ff && awr_ff && in_reg_window(aaddr_ff);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Next state; the states model instruction execution time
    always @* begin
        nxt_state  = state_ff;
        nxt_flags  = flags_ff;
        nxt_rd     = rd_ff;
        nxt_rs     = rs_ff;
        nxt_wsize  = wsize_ff;
        nxt_imm    = imm_ff;
        nxt_states = states_ff;
        nxt_bytes  = bytes_ff;
        nxt_busy   = busy_ff;
        nxt_gr_we  = 1'b0;
        case (state_ff)
            S_IDLE: begin
                // Unknown first bytes are swallowed so a stray byte cannot wedge the decoder
                if (take && is_cmpi_first(ibyte)) begin
                    nxt_rd    = ibyte[2:0];
                    nxt_state = S_CI_H;
                    nxt_busy  = 1'b1;
                end else if (take && is_bcd_add_with_carry_first(ibyte)) begin
                    nxt_rs    = ibyte[2:0];
                    nxt_wsize = ibyte[3];
                    nxt_state = S_DA_B2;
                    nxt_busy  = 1'b1;
                end
            end
            S_CI_H: begin
                if (take) begin
                    nxt_imm   = {ibyte, imm_ff[7:0]};
                    nxt_state = S_CI_L;
                end
            end
            S_CI_L: begin
                if (take) begin
                    nxt_imm   = {imm_ff[15:8], ibyte};
                    nxt_state = S_CI_EX;
                end
            end
            S_CI_EX: begin
                // Only the flags change; there is no write strobe here
                nxt_flags  = cmp_flags;
                nxt_states = `CWDA_CMPI_STATES;
                nxt_bytes  = `CWDA_CMPI_BYTES;
                nxt_state  = S_WAIT;
            end
            S_DA_B2: begin
                if (take) begin
                    nxt_state = is_bcd_add_with_carry_second(ibyte) ? S_DA_B3 : S_SKIP;
                end
            end
            S_DA_B3: begin
                if (take) begin
                    nxt_rd = ibyte[2:0];
                    if (!is_bcd_add_with_carry_last(ibyte)) begin
                        nxt_state = S_SKIP;
                    end else if (wsize_ff) begin
                        nxt_state = S_DA_BAD;
                    end else begin
                        nxt_state = S_DA_EX;
                    end
                end
            end
            S_DA_EX: begin
                // N and V keep their values; Z is sticky across a multi-byte sum
                nxt_flags[`CWDA_FLAG_Z] = flags_ff[`CWDA_FLAG_Z] && (dsum == 8'h00);
                nxt_flags[`CWDA_FLAG_C] = dcarry;
                nxt_gr_we  = 1'b1;
                nxt_states = `CWDA_BCD_ADD_WITH_CARRY_STATES;
                nxt_bytes  = `CWDA_BCD_ADD_WITH_CARRY_BYTES;
                nxt_state  = S_WAIT;
            end
            S_DA_BAD: begin
                // Word size: no defined result, so flags and registers are kept
                nxt_state = S_WAIT;
            end
            S_WAIT: begin
                nxt_busy  = 1'b0;
                nxt_state = S_IDLE;
            end
            S_SKIP: begin
                // A broken instruction is dropped, nothing is written; after a bad second byte its third byte is decoded as a new first byte
                nxt_busy  = 1'b0;
                nxt_state = S_IDLE;
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    // Decoder registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff  <= S_IDLE;
            flags_ff  <= `CWDA_FLAGS_RESET;
            rd_ff     <= 3'h0;
            rs_ff     <= 3'h0;
            wsize_ff  <= 1'b0;
            imm_ff    <= 16'h0000;
            states_ff <= 8'h00;
            bytes_ff  <= 8'h00;
            busy_ff   <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            flags_ff  <= nxt_flags;
            rd_ff     <= nxt_rd;
            rs_ff     <= nxt_rs;
            wsize_ff  <= nxt_wsize;
            imm_ff    <= nxt_imm;
            states_ff <= nxt_states;
            bytes_ff  <= nxt_bytes;
            busy_ff   <= nxt_busy;
        end
    end

    // Register file; the compare has no write path into it at all
    // A bus write meeting the decimal write in one cycle is lost: wait for busy low
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (i = 0; i < 8; i = i + 1) begin
                gr_ff[i] <= 16'h0000;
            end
        end else if (nxt_gr_we) begin
            // Only the low byte takes the decimal sum; the high byte is kept
            gr_ff[rd_ff] <= {dst_word[15:8], dsum};
        end else if (wr_gr) begin
            gr_ff[aaddr_ff[4:2]] <= hwdata[15:0];
        end
    end

    // Read mux; unmapped reads return zero and the flags word is read-only
    always @* begin
        rd_word = 32'h0000_0000;
        if (haddr == `CWDA_ADDR_CTRL) begin
            rd_word = {31'h0000_0000, enable_ff};
        end else if (haddr == `CWDA_ADDR_STAT) begin
            rd_word = {8'h00, bytes_ff, states_ff, 7'h00, busy_ff};
        end else if (haddr == `CWDA_ADDR_FLAGS) begin
            rd_word = {28'h000_0000, flags_ff};
        end else if (in_reg_window(haddr)) begin
            rd_word = {16'h0000, gr_ff[haddr[4:2]]};
        end
    end

    // AHB slave: capture the address phase, answer in the following data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_ff    <= 1'b0;
            awr_ff    <= 1'b0;
            aaddr_ff  <= 32'h0000_0000;
            enable_ff <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end else begin
            aph_ff <= ahb_go;
            if (ahb_go) begin
                awr_ff   <= hwrite;
                aaddr_ff <= haddr;
            end
            // Registered so the read word stands through the whole data phase
            if (ahb_go && !hwrite) begin
                hrdata <= rd_word;
            end
            if (wr_ctrl) begin
                enable_ff <= hwdata[0];
            end
        end
    end
endmodule // cwda_top

// ---- testbench/cwda_chk_sva.sv ----
`timescale 1ns/1ps
`include "cwda_defines.vh"
module cwda_chk (
    input wire        hclk,      // Clock
    input wire        hresetn,   // Reset, low
    input wire        hsel,      // Select
    input wire [31:0] haddr,     // Address
    input wire [1:0]  htrans,    // Transfer
    input wire        hwrite,    // Write
    input wire        hready,    // Ready in
    input wire [31:0] hrdata,    // Read data
    input wire        hreadyout, // Ready out
    input wire        hresp,     // Response
    input wire        ibyte_vld, // Byte valid
    input wire        ibyte_rdy, // Byte taken
    input wire        busy_ff    // Busy
);
    logic rd_a;
    logic fl_ff;
    assign rd_a = hsel && hready && htrans[1] && !hwrite;
    // Mark the data phase of a flags read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) fl_ff <= 1'b0;
        else fl_ff <= rd_a && haddr == `CWDA_ADDR_FLAGS;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_take; ibyte_vld && ibyte_rdy; endsequence
    sequence s_three; (!busy_ff && s_take) ##1 (busy_ff && s_take) ##1 s_take; endsequence
    property p_zero_wait; hreadyout; endproperty
    property p_okay; !hresp; endproperty
    property p_busy_on; s_take |=> busy_ff; endproperty
    property p_busy_cause; $rose(busy_ff) |-> $past(ibyte_vld && ibyte_rdy); endproperty
    property p_exec_gap; s_three |=> !ibyte_rdy; endproperty
    property p_done_soon; s_three |-> ##[1:6] !busy_ff; endproperty
    property p_flags_width; fl_ff |-> hrdata[31:4] == 28'h000_0000; endproperty
    property p_rd_hold; !rd_a |=> $stable(hrdata); endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("wait state");
    a_okay: assert property (p_okay) else $error("bad response");
    a_busy_on: assert property (p_busy_on) else $error("busy low after byte");
    a_busy_cause: assert property (p_busy_cause) else $error("busy w/o byte");
    a_exec_gap: assert property (p_exec_gap) else $error("no exec state");
    a_done_soon: assert property (p_done_soon) else $error("too slow");
    a_flags_width: assert property (p_flags_width) else $error("flag bits");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule // cwda_chk

// ---- testbench/test_compare_word_and_decimal_add.sv ----
`timescale 1ns/1ps
`include "cwda_defines.vh"
module test_compare_word_and_decimal_add;
    logic        hclk, hresetn, hsel, hwrite, ibyte_vld;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  ibyte;
    logic [31:0] haddr, hwdata, rd;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, ibyte_rdy, busy_ff;
    int          miscompares, cmp_count, k;
    localparam logic [31:0] FL = `CWDA_ADDR_FLAGS;
    localparam logic [31:0] R7 = `CWDA_ADDR_REGBASE + 32'h0000_001c;
    localparam logic [31:0] ST = {8'h00, 8'(`CWDA_CMPG_BYTES - 1), 8'(`CWDA_CMPG_STATES - 1), 8'h00};
    // Compare cases, then decimal add cases primed by a compare on r3
    logic [15:0] cv [5] = '{16'h1234, 16'h0000, 16'h8000, 16'h7fff, 16'hffff};
    logic [15:0] ci [5] = '{16'h1234, 16'h0001, 16'h0001, 16'hffff, 16'hffff};
    logic [15:0] pb [5] = '{16'h1234, 16'h0001, 16'h0001, 16'h1234, 16'h0001};
    logic [7:0]  sv [5] = '{8'h01, 8'h38, 8'h50, 8'h34, 8'h99};
    logic [7:0]  dv [5] = '{8'h99, 8'h45, 8'h50, 8'h12, 8'h99};
    logic [7:0]  er [5] = '{8'h00, 8'h84, 8'h00, 8'h46, 8'h99};
    logic [3:0]  ef [5] = '{4'h5, 4'h8, 4'h3, 4'h0, 4'h9};
    logic [3:0]  ce [5] = '{4'h4, 4'h9, 4'h2, 4'hb, 4'h4};
    cwda_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ibyte(ibyte), .ibyte_vld(ibyte_vld),
        .ibyte_rdy(ibyte_rdy), .busy_ff(busy_ff));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task close_out;
        $display("errors %0d in %0d compares", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Look at a falling edge so the next rising edge is the one that takes it
    task waitf(input int sel);
        int n;
        for (n = 0; n < 60; n++) begin
            @(negedge hclk);
            if ((sel == 0 ? hreadyout : sel == 1 ? ibyte_rdy : !busy_ff) === 1'b1) break;
        end
        if (n == 60) begin
            miscompares++;
            close_out();
        end
        @(posedge hclk);
    endtask
    task ahb(input logic wr, input logic [31:0] a, wd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        waitf(0);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        waitf(0);
        rd = hrdata;
    endtask
    task rchk(input logic [31:0] a, exp);
        ahb(1'b0, a, 32'h0000_0000);
        cmp_count++;
        if (rd !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, rd, exp);
        end
    endtask
    // Bytes go back to back; the wait for idle avoids racing the exec state
    task ins(input logic [7:0] b0, b1, b2);
        ibyte     <= b0;
        ibyte_vld <= 1'b1;
        waitf(1);
        ibyte <= b1;
        waitf(1);
        ibyte <= b2;
        waitf(1);
        ibyte     <= ~b2;
        ibyte_vld <= 1'b0;
        waitf(2);
    endtask
    // Reset for 20 cycles, enable the decoder, then run both tables
    initial begin
        {hresetn, hsel, hwrite, ibyte_vld, htrans, ibyte, haddr, hwdata} = '0;
        hsize       = 3'b010;
        miscompares = 0;
        cmp_count   = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(FL, {28'h000_0000, `CWDA_FLAGS_RESET});
        rchk(32'h0000_0100, 32'h0000_0000);
        ahb(1'b1, `CWDA_ADDR_CTRL, 32'h0000_0001);
        for (k = 0; k < 5; k++) begin
            ahb(1'b1, `CWDA_ADDR_REGBASE + 4 * (k + 3), {16'h0000, cv[k]});
            ins({5'b01001, 3'(k + 3)}, ci[k][15:8], ci[k][7:0]);
            rchk(FL, {28'h000_0000, ce[k]});
            rchk(`CWDA_ADDR_REGBASE + 4 * (k + 3), {16'h0000, cv[k]});
            rchk(`CWDA_ADDR_STAT, ST);
        end
        for (k = 0; k < 5; k++) begin
            ahb(1'b1, `CWDA_ADDR_REGBASE + 32'h0000_000c, {16'h0000, cv[k < 3 ? k : k - 3]});
            ahb(1'b1, `CWDA_ADDR_REGBASE, {24'h00_0000, sv[k]});
            ahb(1'b1, R7, {24'h00_0000, dv[k]});
            ins(8'h4b, pb[k][15:8], pb[k][7:0]);
            ins(8'ha0, 8'ha0, 8'ha7);
            rchk(R7, {24'h00_0000, er[k]});
            rchk(FL, {28'h000_0000, ef[k]});
        end
        ins(8'ha8, 8'ha0, 8'ha7);
        rchk(R7, {24'h00_0000, er[4]});
        ahb(1'b1, FL, 32'h0000_0000);
        rchk(FL, {28'h000_0000, ef[4]});
        close_out();
    end
endmodule // test_compare_word_and_decimal_add
bind cwda_top cwda_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ibyte_vld(ibyte_vld), .ibyte_rdy(ibyte_rdy), .busy_ff(busy_ff));
